// ### hdl/banked_saved_status_regs.sv
// Banked saved status words for the interrupt and undefined modes,
// captured on exception entry, restored on return, moved by sysreg ops.
// Assumes the exception sequencer and the sysreg path share CLK_SYS.
//
// Behaviour
// - Undefined entry saves flags N Z C V in bits 31:28; return restores.
// - Interrupt entry saves flags N Z C V in bits 31:28; return restores.
// - Interrupt entry saves no-user-access state in bit 22; return restores.
// - Undefined entry saves no-user-access state in bit 22; return restores.
// - Bit 20 keeps the bad-state flag as it stood before entry.
// - Bits 19:16 keep the four greater-or-equal flags.
// - Bit 27 keeps the cumulative saturation flag.
// - Block state split: low two bits 26:25, upper six bits 15:10.
// - Low five block bits give remaining count and condition bits.
// - Whole block state field is zero when no block is active.
// - Bit 9 gives data byte order, zero little, one big.
// - Current byte order bit takes the endian reset strap at reset.
// - Byte order bit fixed when only one byte order is built.
// - User-only byte order forces bit 9 on returns above user.
// - Bits 8, 7, 6 mask async aborts, interrupts, fast interrupts.
// - Bit 5 keeps which 32-bit instruction set was running.
// - Bit 4 reads one, the 32-bit execution state.
// - Bits 3:0 keep the source mode encoding.
// - Bits 24, 23, 21 read zero; bit 22 zero without the feature.
// - Sysreg moves decode 11/100/0100/0011, op2 picks the bank.
// - Access only from the top level, or top two when non-secure.
// - Both words read zero without 32-bit state at level one.
`timescale 1ns/1ns
`default_nettype none
module banked_saved_status_regs
  import sspsr_pkg::*;
(
  input wire logic CLK_SYS,            // Core clock, 10 MHz
  input wire logic RST_N,              // Synchronous reset, active low
  input wire impl_cfg_t CFG,           // Implementation straps
  input wire logic CFG_EE_RESET,       // Endian reset strap
  input wire logic EXC_ENTRY,          // Exception entry pulse
  input wire logic EXC_TO_UNDEF,       // Entry target: 1 undefined, 0 irq
  input wire status_word_t CUR_STATUS, // Current status word
  input wire logic EXC_RETURN,         // Exception return pulse
  input wire logic RET_FROM_UNDEF,     // Return from: 1 undefined, 0 irq
  input wire logic [1:0] RET_EL,       // Level being returned to
  output status_word_t RESTORE_WORD,   // Word to restore, registered
  output logic RESTORE_VALID,          // Restore word valid pulse
  output logic DATA_BIG_ENDIAN,        // Current data byte order
  input wire logic SR_VALID,           // Sysreg move request
  input wire logic SR_WRITE,           // 1 write, 0 read
  input wire sysreg_enc_t SR_ENC,      // Sysreg encoding fields
  input wire logic [1:0] SR_EL,        // Requesting privilege level
  input wire logic SR_NS,              // Non-secure when 1
  input wire logic [31:0] SR_WDATA,    // Write data
  output logic [31:0] SR_RDATA,        // Read data, registered
  output logic SR_DONE,                // Access completed pulse
  output logic SR_FAULT                // Access refused pulse
);

  status_word_t irq_r;
  status_word_t und_r;
  status_word_t entry_clean;
  status_word_t wdata_clean;
  status_word_t ret_src;
  status_word_t restore_nxt;
  status_word_t restore_r;
  logic restore_vld_r;
  logic big_endian_r;
  logic [31:0] rdata_r;
  logic done_r;
  logic fault_r;
  logic enc_hit;
  logic sel_irq;
  logic sel_und;
  logic access_ok;
  logic wr_irq;
  logic wr_und;
  logic ent_irq;
  logic ent_und;
  logic [7:0] irq_it;
  logic [7:0] und_it;

  // Privilege gate shared by both banks
  function automatic logic level_ok(input logic [1:0] el, input logic ns);
    logic ok;
    ok = 1'b0;
    if (el == EL_TOP)
    begin
      ok = 1'b1;
    end
    else if (el == EL_HYP)
    begin
      ok = ns;
    end
    level_ok = ok;
  endfunction

  // Entry word and write data pass the same cleaner, so software can
  // never plant a reserved bit that hardware would not
  status_word_clean u_entry_clean (
    .word_in (CUR_STATUS),
    .cfg (CFG),
    .word_out (entry_clean)
  );

  status_word_clean u_wdata_clean (
    .word_in (status_word_t'(SR_WDATA)),
    .cfg (CFG),
    .word_out (wdata_clean)
  );

  // Sysreg decode and access check
  assign enc_hit = (SR_ENC.op0 == SR_OP0) && (SR_ENC.op1 == SR_OP1) &&
                   (SR_ENC.crn == SR_CRN) && (SR_ENC.crm == SR_CRM);
  assign sel_irq = enc_hit && (SR_ENC.op2 == SR_OP2_IRQ);
  assign sel_und = enc_hit && (SR_ENC.op2 == SR_OP2_UND);
  assign access_ok = level_ok(SR_EL, SR_NS);
  assign wr_irq = SR_VALID && SR_WRITE && sel_irq && access_ok;
  assign wr_und = SR_VALID && SR_WRITE && sel_und && access_ok;
  assign ent_irq = EXC_ENTRY && !EXC_TO_UNDEF;
  assign ent_und = EXC_ENTRY && EXC_TO_UNDEF;

  // Interrupt bank: entry beats a same-cycle software write
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      irq_r <= SAVED_RESET;
    end
    else if (ent_irq)
    begin
      irq_r <= entry_clean;
    end
    else if (wr_irq)
    begin
      irq_r <= wdata_clean;
    end
  end

  // Undefined bank: same priority as the interrupt bank
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      und_r <= SAVED_RESET;
    end
    else if (ent_und)
    begin
      und_r <= entry_clean;
    end
    else if (wr_und)
    begin
      und_r <= wdata_clean;
    end
  end

  // Restore word; a same-cycle entry is seen only after this return
  always_comb
  begin
    ret_src = RET_FROM_UNDEF ? und_r : irq_r;
    restore_nxt = ret_src;
    if (RET_EL != EL_USER)
    begin
      if (CFG.be_el0_only)
      begin
        restore_nxt.e = 1'b0;
      end
      else if (CFG.le_el0_only)
      begin
        restore_nxt.e = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      restore_r <= WORD_ZERO;
      restore_vld_r <= 1'b0;
    end
    else
    begin
      restore_vld_r <= EXC_RETURN;
      if (EXC_RETURN)
      begin
        restore_r <= restore_nxt;
      end
    end
  end

  // Current data byte order: strap at reset, restored word on return when CFG.el1_aa32 is set
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      big_endian_r <= CFG_EE_RESET;
    end
    else if (EXC_RETURN && CFG.el1_aa32)
    begin
      big_endian_r <= restore_nxt.e;
    end
  end

  // Sysreg response, one cycle after the request
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      rdata_r <= WORD_ZERO;
      done_r <= 1'b0;
      fault_r <= 1'b0;
    end
    else
    begin
      done_r <= SR_VALID;
      fault_r <= SR_VALID && !((sel_irq || sel_und) && access_ok);
      if (SR_VALID && !SR_WRITE && access_ok && CFG.el1_aa32)
      begin
        if (sel_irq)
        begin
          rdata_r <= irq_r;
        end
        else if (sel_und)
        begin
          rdata_r <= und_r;
        end
        else
        begin
          rdata_r <= WORD_ZERO;
        end
      end
      else if (SR_VALID)
      begin
        rdata_r <= WORD_ZERO;
      end
    end
  end

  assign RESTORE_WORD = restore_r;
  assign RESTORE_VALID = restore_vld_r;
  assign DATA_BIG_ENDIAN = big_endian_r;
  assign SR_RDATA = rdata_r;
  assign SR_DONE = done_r;
  assign SR_FAULT = fault_r;

  // Checks
  sequence s_entry_und;
    EXC_ENTRY && EXC_TO_UNDEF && CFG.el1_aa32;
  endsequence

  sequence s_entry_irq;
    EXC_ENTRY && !EXC_TO_UNDEF && CFG.el1_aa32;
  endsequence

  property p_und_flags;
    @(posedge CLK_SYS) disable iff (!RST_N)
    s_entry_und |=> und_r[BIT_N:BIT_V] == $past(CUR_STATUS[BIT_N:BIT_V]);
  endproperty
  a_und_flags: assert property (p_und_flags)
    else $error("undefined bank flags not captured");

  property p_irq_flags;
    @(posedge CLK_SYS) disable iff (!RST_N)
    s_entry_irq |=> irq_r[BIT_N:BIT_V] == $past(CUR_STATUS[BIT_N:BIT_V]);
  endproperty
  a_irq_flags: assert property (p_irq_flags)
    else $error("irq bank flags not captured");

  property p_irq_pan;
    @(posedge CLK_SYS) disable iff (!RST_N)
    s_entry_irq |=> irq_r[BIT_PAN] == ($past(CUR_STATUS[BIT_PAN]) && CFG.privileged_no_user_access);
  endproperty
  a_irq_pan: assert property (p_irq_pan)
    else $error("irq bank access-state bit wrong");

  property p_und_pan_il;
    @(posedge CLK_SYS) disable iff (!RST_N)
    s_entry_und |=> (und_r[BIT_PAN] == ($past(CUR_STATUS[BIT_PAN]) && CFG.privileged_no_user_access))
                    && (und_r[BIT_IL] == $past(CUR_STATUS[BIT_IL]));
  endproperty
  a_und_pan_il: assert property (p_und_pan_il)
    else $error("undefined bank access-state or bad-state bit wrong");

  property p_reserved;
    @(posedge CLK_SYS) disable iff (!RST_N)
    !irq_r[BIT_OLD_ISA] && !irq_r[BIT_RSV23] && !irq_r[BIT_RSV21] &&
    !und_r[BIT_OLD_ISA] && !und_r[BIT_RSV23] && !und_r[BIT_RSV21];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit set in saved word");

  // Gathered block state of both banks for the idle check
  assign irq_it = it_of(irq_r);
  assign und_it = it_of(und_r);

  property p_it_idle;
    @(posedge CLK_SYS) disable iff (!RST_N)
    ((und_it[4:0] == IT_IDLE) |-> (und_it == '0)) and
    ((irq_it[4:0] == IT_IDLE) |-> (irq_it == '0));
  endproperty
  a_it_idle: assert property (p_it_idle)
    else $error("block state not zero while idle");

  property p_deny_user;
    @(posedge CLK_SYS) disable iff (!RST_N)
    SR_VALID && (SR_EL == EL_USER || SR_EL == EL_ONE) |=>
      SR_FAULT && SR_DONE && (SR_RDATA == WORD_ZERO);
  endproperty
  a_deny_user: assert property (p_deny_user)
    else $error("low level access not refused");

  property p_restore_und;
    @(posedge CLK_SYS) disable iff (!RST_N)
    EXC_RETURN && RET_FROM_UNDEF |=> RESTORE_VALID &&
      (RESTORE_WORD[BIT_N:BIT_V] == $past(und_r[BIT_N:BIT_V])) &&
      (RESTORE_WORD[BIT_PAN] == $past(und_r[BIT_PAN]));
  endproperty
  a_restore_und: assert property (p_restore_und)
    else $error("return did not restore undefined bank flags");

  property p_ret_endian;
    @(posedge CLK_SYS) disable iff (!RST_N)
    EXC_RETURN && RET_EL != EL_USER && CFG.be_el0_only |=>
      !RESTORE_WORD.e && !DATA_BIG_ENDIAN;
  endproperty
  a_ret_endian: assert property (p_ret_endian)
    else $error("user-only byte order leaked to higher level");

  property p_no_aa32;
    @(posedge CLK_SYS) disable iff (!RST_N)
    !CFG.el1_aa32 && SR_VALID && !SR_WRITE |=> SR_RDATA == WORD_ZERO;
  endproperty
  a_no_aa32: assert property (p_no_aa32)
    else $error("saved word readable without 32-bit state");

endmodule
`default_nettype wire

// ### hdl/status_word_clean.sv
// Combinational cleaner that forces the fixed and reserved bits of a
// saved status word. Assumes the configuration straps are static.
`timescale 1ns/1ns
`default_nettype none
module status_word_clean
  import sspsr_pkg::*;
(
  input wire status_word_t word_in, // Raw word
  input wire impl_cfg_t cfg,        // Implementation options
  output status_word_t word_out     // Word with fixed bits applied
);

  logic [7:0] it_in; // Gathered block state of the raw word

  // A function result cannot be part-selected, so gather it first
  assign it_in = it_of(word_in);

  // Reserved bits, execution state marker, byte order and idle block
  always_comb
  begin
    word_out = word_in;
    word_out.old_isa = 1'b0;
    word_out.rsv23 = 1'b0;
    word_out.rsv21 = 1'b0;
    if (!cfg.privileged_no_user_access)
    begin
      word_out.privileged_no_user_access = 1'b0;
    end
    word_out.m4 = 1'b1;
    if (!cfg.be)
    begin
      word_out.e = 1'b0;
    end
    else if (!cfg.le)
    begin
      word_out.e = 1'b1;
    end
    // No active block means the whole field is zero
    if (it_in[4:0] == IT_IDLE)
    begin
      word_out.it_hi = '0;
      word_out.it_lo = '0;
    end
    // Without the 32-bit state at level one the word does not exist
    if (!cfg.el1_aa32)
    begin
      word_out = WORD_ZERO;
    end
  end

endmodule
`default_nettype wire

// ### inc/sspsr_pkg.sv
// Package for the banked saved status word pair: field positions,
// mode and privilege codes, system-register encodings and carrier types.
// Assumes a single core clock domain shared with the exception sequencer.
package sspsr_pkg;

  // Field positions within a 32-bit saved status word
  localparam int BIT_N = 31;
  localparam int BIT_V = 28;
  localparam int BIT_Q = 27;
  localparam int BIT_IT_LO_HI = 26;
  localparam int BIT_IT_LO_LO = 25;
  localparam int BIT_OLD_ISA = 24;
  localparam int BIT_RSV23 = 23;
  localparam int BIT_PAN = 22;
  localparam int BIT_RSV21 = 21;
  localparam int BIT_IL = 20;
  localparam int BIT_GE_HI = 19;
  localparam int BIT_GE_LO = 16;
  localparam int BIT_IT_HI_HI = 15;
  localparam int BIT_IT_HI_LO = 10;
  localparam int BIT_E = 9;
  localparam int BIT_M4 = 4;

  // Source mode encodings
  localparam logic [3:0] MODE_USER = 4'h0;
  localparam logic [3:0] MODE_FIQ = 4'h1;
  localparam logic [3:0] MODE_IRQ = 4'h2;
  localparam logic [3:0] MODE_SVC = 4'h3;
  localparam logic [3:0] MODE_MON = 4'h6;
  localparam logic [3:0] MODE_ABT = 4'h7;
  localparam logic [3:0] MODE_HYP = 4'hA;
  localparam logic [3:0] MODE_UND = 4'hB;
  localparam logic [3:0] MODE_SYS = 4'hF;

  // Privilege levels
  localparam logic [1:0] EL_USER = 2'h0;
  localparam logic [1:0] EL_ONE = 2'h1;
  localparam logic [1:0] EL_HYP = 2'h2;
  localparam logic [1:0] EL_TOP = 2'h3;

  // System-register move encoding of the two saved words
  localparam logic [1:0] SR_OP0 = 2'h3;
  localparam logic [2:0] SR_OP1 = 3'h4;
  localparam logic [3:0] SR_CRN = 4'h4;
  localparam logic [3:0] SR_CRM = 4'h3;
  localparam logic [2:0] SR_OP2_IRQ = 3'h0;
  localparam logic [2:0] SR_OP2_UND = 3'h2;

  // Reset value: only the 32-bit execution state marker set
  localparam logic [31:0] SAVED_RESET = 32'h0000_0010;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [4:0] IT_IDLE = 5'h00;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
    logic q;
    logic [1:0] it_lo;
    logic old_isa;
    logic rsv23;
    logic privileged_no_user_access;
    logic rsv21;
    logic il;
    logic [3:0] ge;
    logic [5:0] it_hi;
    logic e;
    logic a;
    logic i;
    logic f;
    logic t;
    logic m4;
    logic [3:0] mode;
  } status_word_t;

  typedef struct packed {
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } sysreg_enc_t;

  typedef struct packed {
    logic el1_aa32;    // First privileged level can run the 32-bit state
    logic privileged_no_user_access;         // Privileged-no-user-access feature present
    logic be;          // Big-endian data supported
    logic le;          // Little-endian data supported
    logic be_el0_only; // Big-endian only at the user level
    logic le_el0_only; // Little-endian only at the user level
  } impl_cfg_t;

  // Conditional-block state gathered from its two split fields
  function automatic logic [7:0] it_of(input status_word_t w);
    it_of = {w.it_hi, w.it_lo};
  endfunction

endpackage

// ### sim/exc_seq_model.sv
// Model of the core's exception entry and return sequencer.
// Assumes the bench calls its tasks at a falling edge of the core clock.
`timescale 1ns/1ns
`default_nettype none
module exc_seq_model
  import sspsr_pkg::*;
(
  input wire logic clk,     // Core clock
  output logic entry,       // Entry pulse
  output logic to_undef,    // Entry target bank
  output status_word_t cur, // Current status word
  output logic ret,         // Return pulse
  output logic from_undef,  // Return source bank
  output logic [1:0] ret_el // Level returned to
);
  // Quiet at start
  initial
  begin
    entry = 1'b0;
    ret = 1'b0;
    to_undef = 1'b0;
    cur = WORD_ZERO;
    from_undef = 1'b0;
    ret_el = EL_USER;
  end

  // One-cycle entry; qualifiers turned over after the take so a stale
  // value can never pass for a fresh one
  task automatic take(input logic und, input status_word_t s);
    @(negedge clk);
    entry = 1'b1;
    to_undef = und;
    cur = s;
    @(negedge clk);
    entry = 1'b0;
    to_undef = ~und;
    cur = ~s;
  endtask

  // One-cycle return, same scrambling afterwards
  task automatic give_back(input logic und, input logic [1:0] el);
    @(negedge clk);
    ret = 1'b1;
    from_undef = und;
    ret_el = el;
    @(negedge clk);
    ret = 1'b0;
    from_undef = ~und;
    ret_el = ~el;
  endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the banked saved status word pair.
// Assumes the sequencer model drives entries and returns.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      $display("wrong value %s exp %h got %h", nm, e, g); \
      miscompares++; \
    end \
  end
module testbench
  import sspsr_pkg::*;
;
  localparam impl_cfg_t FULL = 6'h3C;
  int miscompares = 0;
  int checks_done = 0;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  impl_cfg_t CFG = FULL;
  logic CFG_EE_RESET = 1'b0;
  logic EXC_ENTRY, EXC_TO_UNDEF, EXC_RETURN, RET_FROM_UNDEF;
  status_word_t CUR_STATUS, RESTORE_WORD;
  logic [1:0] RET_EL, SR_EL;
  logic RESTORE_VALID, DATA_BIG_ENDIAN, SR_DONE, SR_FAULT;
  logic SR_VALID, SR_WRITE, SR_NS, flt;
  sysreg_enc_t SR_ENC;
  logic [31:0] SR_WDATA, SR_RDATA, rd;

  // Core clock, 100 ns period
  always #50 CLK_SYS = ~CLK_SYS;

  banked_saved_status_regs dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .CFG(CFG), .CFG_EE_RESET(CFG_EE_RESET), .EXC_ENTRY(EXC_ENTRY),
    .EXC_TO_UNDEF(EXC_TO_UNDEF), .CUR_STATUS(CUR_STATUS),
    .EXC_RETURN(EXC_RETURN), .RET_FROM_UNDEF(RET_FROM_UNDEF),
    .RET_EL(RET_EL), .RESTORE_WORD(RESTORE_WORD),
    .RESTORE_VALID(RESTORE_VALID), .DATA_BIG_ENDIAN(DATA_BIG_ENDIAN),
    .SR_VALID(SR_VALID), .SR_WRITE(SR_WRITE), .SR_ENC(SR_ENC),
    .SR_EL(SR_EL), .SR_NS(SR_NS), .SR_WDATA(SR_WDATA),
    .SR_RDATA(SR_RDATA), .SR_DONE(SR_DONE), .SR_FAULT(SR_FAULT));

  exc_seq_model seq (.clk(CLK_SYS), .entry(EXC_ENTRY),
    .to_undef(EXC_TO_UNDEF), .cur(CUR_STATUS), .ret(EXC_RETURN),
    .from_undef(RET_FROM_UNDEF), .ret_el(RET_EL));

  function automatic sysreg_enc_t enc(input logic [2:0] op2);
    return {SR_OP0, SR_OP1, SR_CRN, SR_CRM, op2};
  endfunction

  // Expected stored word, fixed bits forced by the straps
  function automatic logic [31:0] cln(input logic [31:0] w,
    input impl_cfg_t c);
    status_word_t s;
    s = w;
    s.old_isa = 1'b0;
    s.rsv23 = 1'b0;
    s.rsv21 = 1'b0;
    s.privileged_no_user_access = s.privileged_no_user_access & c.privileged_no_user_access;
    s.m4 = 1'b1;
    if (!c.be)
      s.e = 1'b0;
    else if (!c.le)
      s.e = 1'b1;
    if ({s.it_hi[2:0], s.it_lo} == 5'h00)
    begin
      s.it_hi = 6'h00;
      s.it_lo = 2'h0;
    end
    return c.el1_aa32 ? s : WORD_ZERO;
  endfunction

  task automatic end_sim();
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic do_reset(input impl_cfg_t c, input logic ee);
    @(negedge CLK_SYS);
    RST_N = 1'b0;
    CFG = c;
    CFG_EE_RESET = ee;
    repeat (8) @(negedge CLK_SYS);
    RST_N = 1'b1;
  endtask

  // One sysreg move; the answer is due exactly one cycle after the take
  task automatic sr_op(input logic wr, input sysreg_enc_t e,
    input logic [31:0] wd);
    @(negedge CLK_SYS);
    SR_VALID = 1'b1;
    SR_WRITE = wr;
    SR_ENC = e;
    SR_WDATA = wd;
    @(negedge CLK_SYS);
    SR_VALID = 1'b0;
    SR_WDATA = ~wd;
    `CHK("sysreg done", 1'b1, SR_DONE)
    rd = SR_RDATA;
    flt = SR_FAULT;
  endtask

  task automatic rd_chk(input logic [2:0] op2, input logic [31:0] exp);
    sr_op(1'b0, enc(op2), 32'h0000_0000);
    `CHK("read data", exp, rd)
    `CHK("read fault", 1'b0, flt)
  endtask

  // Reset values of both words and the endian strap
  task automatic t_reset(input logic ee);
    do_reset(FULL, ee);
    `CHK("endian at reset", ee, DATA_BIG_ENDIAN)
    rd_chk(SR_OP2_IRQ, SAVED_RESET);
    rd_chk(SR_OP2_UND, SAVED_RESET);
  endtask

  // Both banks captured before either is read, so crosstalk shows
  task automatic t_capture();
    logic [31:0] pat [2] = '{32'h6B3C_0962, 32'hFB5A_F6CB};
    for (int b = 0; b < 2; b++)
      seq.take(b[0], pat[b]);
    for (int b = 0; b < 2; b++)
    begin
      rd_chk(b ? SR_OP2_UND : SR_OP2_IRQ, cln(pat[b], FULL));
      seq.give_back(b[0], EL_ONE);
      `CHK("restored", cln(pat[b], FULL), RESTORE_WORD)
      `CHK("restore valid", 1'b1, RESTORE_VALID)
      `CHK("data endian", pat[b][BIT_E], DATA_BIG_ENDIAN)
    end
    seq.take(1'b1, 32'h0000_E00B);
    rd_chk(SR_OP2_UND, 32'h0000_001B);
  endtask

  // Software writes, reserved bits and every mode code
  task automatic t_sysreg();
    logic [3:0] modes [9] = '{MODE_USER, MODE_FIQ, MODE_IRQ, MODE_SVC,
      MODE_MON, MODE_ABT, MODE_HYP, MODE_UND, MODE_SYS};
    sr_op(1'b1, enc(SR_OP2_IRQ), 32'hFFFF_FFFF);
    rd_chk(SR_OP2_IRQ, 32'hFE5F_FFFF);
    foreach (modes[k])
    begin
      sr_op(1'b1, enc(SR_OP2_UND), {28'h0, modes[k]});
      rd_chk(SR_OP2_UND, {27'h0, 1'b1, modes[k]});
    end
  endtask

  // Level and security gate; a refused write leaves the word alone
  task automatic t_access();
    sysreg_enc_t bad [2] = '{enc(3'h3), {SR_OP0, SR_OP1, SR_CRN, 4'h0,
      3'h0}};
    logic [31:0] last = 32'h0000_0010;
    logic ok;
    sr_op(1'b1, enc(SR_OP2_IRQ), last);
    for (int k = 0; k < 8; k++)
    begin
      // Let an edge pass so the level is not set twice in one step
      @(negedge CLK_SYS);
      ok = (k[1:0] == EL_TOP) || (k[1:0] == EL_HYP && k[2]);
      SR_EL = k[1:0];
      SR_NS = k[2];
      sr_op(1'b1, enc(SR_OP2_IRQ), {k[2:0], 29'h10});
      `CHK("gate fault", !ok, flt)
      if (ok)
        last = {k[2:0], 29'h10};
      sr_op(1'b0, enc(SR_OP2_IRQ), 32'h0000_0000);
      `CHK("gated read", ok ? last : WORD_ZERO, rd)
      SR_EL = EL_TOP;
      SR_NS = 1'b0;
      rd_chk(SR_OP2_IRQ, last);
    end
    foreach (bad[j])
    begin
      sr_op(1'b0, bad[j], 32'h0000_0000);
      `CHK("foreign fault", 1'b1, flt)
      `CHK("foreign data", WORD_ZERO, rd)
    end
  endtask

  // Single byte order builds, then user-only byte order on returns
  task automatic t_endian();
    impl_cfg_t cf [2] = '{6'h34, 6'h38};
    foreach (cf[j])
    begin
      do_reset(cf[j], j == 1);
      sr_op(1'b1, enc(SR_OP2_IRQ), 32'h0000_0212);
      rd_chk(SR_OP2_IRQ, cln(32'h0000_0212, cf[j]));
    end
    for (int j = 0; j < 2; j++)
    begin
      do_reset(j ? 6'h3D : 6'h3E, 1'b0);
      sr_op(1'b1, enc(SR_OP2_IRQ), {22'h0, ~j[0], 9'h012});
      seq.give_back(1'b0, EL_ONE);
      `CHK("endian above user", j[0], RESTORE_WORD.e)
      `CHK("endian follows", j[0], DATA_BIG_ENDIAN)
      seq.give_back(1'b0, EL_USER);
      `CHK("endian at user", ~j[0], RESTORE_WORD.e)
      `CHK("endian at user data", ~j[0], DATA_BIG_ENDIAN)
    end
  endtask

  // No 32-bit state at level one: both words read zero without fault
  task automatic t_no_aa32();
    do_reset(6'h1C, 1'b0);
    seq.take(1'b0, 32'hFFFF_FFF2);
    sr_op(1'b1, enc(SR_OP2_UND), 32'hFFFF_FFFB);
    rd_chk(SR_OP2_IRQ, WORD_ZERO);
    rd_chk(SR_OP2_UND, WORD_ZERO);
  endtask

  // Main sequence
  initial
  begin
    SR_VALID = 1'b0;
    SR_WRITE = 1'b0;
    SR_ENC = enc(SR_OP2_IRQ);
    SR_EL = EL_TOP;
    SR_NS = 1'b0;
    SR_WDATA = 32'h0000_0000;
    t_reset(1'b1);
    t_capture();
    t_sysreg();
    t_access();
    t_endian();
    t_no_aa32();
    t_reset(1'b0);
    end_sim();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge CLK_SYS);
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
